// ---- shared/ssp_pkg.sv ----
// constants and carrier types for the flash sleep and pause control block
// What this block does
// - device sits in standby while chip select is high and nothing is busy
// - in deep sleep every command except the wake opcode is ignored
// - opcode b9 then chip select high enters deep sleep within the entry time
// - bits clocked in after the eight-bit sleep or wake opcode are discarded
// - short or misaligned sleep opcode aborts and the device stays in standby
// - after power-up the device starts in standby, not deep sleep
// - sleep opcode is ignored while a self-timed program or erase runs
// - opcode ab then chip select high returns to standby within the exit time
// - short or misaligned wake opcode aborts and the device stays in deep sleep
// - pause never suspends a running self-timed program or erase cycle
// - pause may only be entered while chip select is asserted
// - pause starts with pause pin low during clock low, else next low phase
// - device stays paused while pause pin and chip select stay asserted
// - while paused, serial output floats and serial input and clock are ignored
// - write guard pin keeps taking effect while paused
// - pause ends with pause pin high during clock low, else next low phase
// - chip select high while paused aborts the operation and clears write latch, unless wel_set arrives in the same cycle while awake
package ssp_pkg;

  // ==========================================================================
  // opcodes and framing
  localparam logic [7:0] SSP_OP_SLEEP  = 8'hb9;
  localparam logic [7:0] SSP_OP_WAKE   = 8'hab;
  localparam logic [2:0] SSP_BIT_LAST  = 3'h7;
  localparam logic [2:0] SSP_BIT_ZERO  = 3'h0;
  localparam int         SSP_SYNC_LEN  = 2;

  // ==========================================================================
  // timing
  localparam int SSP_CLK_PERIOD_PS   = 4000;
  localparam int SSP_SLEEP_ENTRY_PS  = 1000000;
  localparam int SSP_SLEEP_EXIT_PS   = 1000000;
  // longest times round down, at least one cycle
  localparam int SSP_ENTRY_CYC = (SSP_SLEEP_ENTRY_PS / SSP_CLK_PERIOD_PS) > 0 ?
                                 (SSP_SLEEP_ENTRY_PS / SSP_CLK_PERIOD_PS) : 1;
  localparam int SSP_EXIT_CYC  = (SSP_SLEEP_EXIT_PS / SSP_CLK_PERIOD_PS) > 0 ?
                                 (SSP_SLEEP_EXIT_PS / SSP_CLK_PERIOD_PS) : 1;
  localparam int SSP_TMR_W     = 16;

  // ==========================================================================
  // power states
  typedef enum logic [1:0] {
    SSP_ST_STANDBY = 2'h0,
    SSP_ST_ENTER   = 2'h1,
    SSP_ST_SLEEP   = 2'h2,
    SSP_ST_EXIT    = 2'h3
  } ssp_state_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic pause_n;
    logic guard_n;
  } ssp_pins_t;

  localparam ssp_pins_t SSP_PINS_IDLE = 5'h1b;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } ssp_cmd_t;

  localparam ssp_cmd_t SSP_CMD_NONE = 9'h000;

endpackage : ssp_pkg

// ---- hw/ssp_ctrl.sv ----
// sleep, wake and pause front end of a serial flash slave port
`timescale 1ns/100ps
module ssp_ctrl
  import ssp_pkg::*;
#(
  parameter int ENTRY_CYC = SSP_ENTRY_CYC,
  parameter int EXIT_CYC  = SSP_EXIT_CYC
)(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // serial pins, asynchronous to clk
  input  wire ssp_pins_t pins,
  output logic           so_r,
  output logic           so_oe_r,
  // core side, same clock
  input  wire logic      busy,
  input  wire logic      core_so,
  input  wire logic      core_so_en,
  input  wire logic      wel_set,
  input  wire logic      wel_clr,
  // status and command out
  output ssp_cmd_t       cmd_r,
  output logic           standby_r,
  output logic           deep_sleep_r,
  output logic           paused_r,
  output logic           write_latch_flag_r,
  output logic           write_guard_r,
  output logic           abort_r
);

  // ==========================================================================
  // pin synchronisers
  ssp_pins_t  meta_r;
  ssp_pins_t  pin_r;
  logic       sck_d_r;
  logic       sel_d_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= SSP_PINS_IDLE;
      pin_r  <= SSP_PINS_IDLE;
    end
    else
    begin
      meta_r <= pins;
      pin_r  <= meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_r <= SSP_PINS_IDLE.sck;                   // idle level: no false rise after reset
      sel_d_r <= 1'b0;
    end
    else
    begin
      sck_d_r <= pin_r.sck;
      sel_d_r <= !pin_r.cs_n;
    end
  end

  logic sel;
  logic sck_rise;
  logic cs_rise;
  logic pause_req;

  assign sel       = !pin_r.cs_n;
  assign sck_rise  = pin_r.sck && !sck_d_r;
  assign cs_rise   = sel_d_r && !sel;
  assign pause_req = !pin_r.pause_n;

  // ==========================================================================
  // pause tracking
  // a level change only counts during the clock low phase, which also covers
  // a change seen in the high phase: it takes effect once the clock drops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      paused_r <= 1'b0;
    else if (!sel)
      paused_r <= 1'b0;
    else if (!pin_r.sck)
      paused_r <= pause_req;
  end

  // ==========================================================================
  // opcode shifter
  logic [6:0] sh_r;
  logic [2:0] bit_cnt_r;
  logic       op_done_r;
  logic [7:0] op_r;
  logic [7:0] byte_in;

  assign byte_in = {sh_r, pin_r.si};

  // clock and data are ignored while paused
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_r      <= 7'h00;
      bit_cnt_r <= SSP_BIT_ZERO;
    end
    else if (!sel)
    begin
      sh_r      <= 7'h00;
      bit_cnt_r <= SSP_BIT_ZERO;
    end
    else if (sck_rise && !paused_r)
    begin
      sh_r      <= byte_in[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // only the first byte is kept; later bits just advance the count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_done_r <= 1'b0;
      op_r      <= 8'h00;
    end
    else if (!sel)
      op_done_r <= 1'b0;
    else if (sck_rise && !paused_r && bit_cnt_r == SSP_BIT_LAST && !op_done_r)
    begin
      op_done_r <= 1'b1;
      op_r      <= byte_in;
    end
  end

  logic aligned;
  assign aligned = op_done_r && bit_cnt_r == SSP_BIT_ZERO;

  // ==========================================================================
  // power state machine
  ssp_state_t          state_r;
  logic [SSP_TMR_W-1:0] tmr_r;
  logic                sleep_ok;
  logic                wake_ok;
  logic                hold_abort;

  assign hold_abort = cs_rise && paused_r;
  assign sleep_ok   = cs_rise && !paused_r && aligned && op_r == SSP_OP_SLEEP && !busy;
  assign wake_ok    = cs_rise && !paused_r && aligned && op_r == SSP_OP_WAKE;

  // during the entry and exit windows commands see the state being left
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SSP_ST_STANDBY;
      tmr_r   <= '0;
    end
    else
    begin
      unique case (state_r)
        SSP_ST_STANDBY:
        begin
          tmr_r <= '0;
          if (sleep_ok)
            state_r <= SSP_ST_ENTER;
        end
        SSP_ST_ENTER:
        begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == SSP_TMR_W'(ENTRY_CYC - 1))
          begin
            state_r <= SSP_ST_SLEEP;
            tmr_r   <= '0;
          end
        end
        SSP_ST_SLEEP:
        begin
          tmr_r <= '0;
          if (wake_ok)
            state_r <= SSP_ST_EXIT;
        end
        SSP_ST_EXIT:
        begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == SSP_TMR_W'(EXIT_CYC - 1))
          begin
            state_r <= SSP_ST_STANDBY;
            tmr_r   <= '0;
          end
        end
      endcase
    end
  end

  logic awake;
  assign awake = state_r == SSP_ST_STANDBY || state_r == SSP_ST_ENTER;

  // ==========================================================================
  // command forwarding and abort report
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_r <= SSP_CMD_NONE;
    else if (awake && sel && sck_rise && !paused_r && bit_cnt_r == SSP_BIT_LAST
             && !op_done_r)
      cmd_r <= '{valid: 1'b1, opcode: byte_in};
    else
      cmd_r <= '{valid: 1'b0, opcode: cmd_r.opcode};
  end

  // misaligned or short frames and frames cut off during pause
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      abort_r <= 1'b0;
    else
      abort_r <= cs_rise && (paused_r || (!aligned && bit_cnt_r != SSP_BIT_ZERO)
                 || (sel_d_r && !op_done_r));
  end

  // ==========================================================================
  // status
  // busy passes through untouched by pause, so a running cycle still holds off standby
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      standby_r    <= 1'b1;
      deep_sleep_r <= 1'b0;
    end
    else
    begin
      standby_r    <= state_r == SSP_ST_STANDBY && !sel && !busy;
      deep_sleep_r <= state_r == SSP_ST_SLEEP || state_r == SSP_ST_EXIT;
    end
  end

  // while awake, set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      write_latch_flag_r <= 1'b0;
    else if (wel_set && awake)
      write_latch_flag_r <= 1'b1;
    else if (hold_abort || wel_clr)
      write_latch_flag_r <= 1'b0;
  end

  // guard level is never frozen by pause
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      write_guard_r <= 1'b0;
    else
      write_guard_r <= !pin_r.guard_n;
  end

  // ==========================================================================
  // serial output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else
    begin
      so_r    <= core_so;
      so_oe_r <= core_so_en && awake && sel && !paused_r;
    end
  end

  // ==========================================================================
  // checks
  sequence s_sleep_frame;
    sleep_ok && state_r == SSP_ST_STANDBY;
  endsequence

  sequence s_in_enter;
    state_r == SSP_ST_ENTER;
  endsequence

  property p_standby;
    @(posedge clk) disable iff (!rst_n)
    (state_r == SSP_ST_STANDBY && !sel && !busy) |=> standby_r;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not shown while idle");

  property p_sleep_ignore;
    @(posedge clk) disable iff (!rst_n)
    (state_r == SSP_ST_SLEEP && $past(state_r) == SSP_ST_SLEEP) |-> !cmd_r.valid;
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore)
    else $error("command forwarded in deep sleep");

  property p_entry_start;
    @(posedge clk) disable iff (!rst_n)
    s_sleep_frame |=> s_in_enter ##0 (tmr_r == '0);
  endproperty
  a_entry_start: assert property (p_entry_start)
    else $error("sleep frame did not start entry");

  property p_entry_bound;
    @(posedge clk) disable iff (!rst_n)
    s_in_enter |-> tmr_r < SSP_TMR_W'(ENTRY_CYC);
  endproperty
  a_entry_bound: assert property (p_entry_bound)
    else $error("entry time exceeded");

  property p_short_abort;
    @(posedge clk) disable iff (!rst_n)
    (cs_rise && !aligned && state_r == SSP_ST_STANDBY) |=> state_r == SSP_ST_STANDBY;
  endproperty
  a_short_abort: assert property (p_short_abort)
    else $error("misaligned sleep frame left standby");

  property p_busy_ignore;
    @(posedge clk) disable iff (!rst_n)
    (cs_rise && busy && state_r == SSP_ST_STANDBY) |=> state_r == SSP_ST_STANDBY;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("sleep accepted while busy");

  property p_wake_abort;
    @(posedge clk) disable iff (!rst_n)
    (cs_rise && !wake_ok && state_r == SSP_ST_SLEEP) |=> state_r == SSP_ST_SLEEP;
  endproperty
  a_wake_abort: assert property (p_wake_abort)
    else $error("bad wake frame left deep sleep");

  property p_exit_bound;
    @(posedge clk) disable iff (!rst_n)
    state_r == SSP_ST_EXIT |-> tmr_r < SSP_TMR_W'(EXIT_CYC);
  endproperty
  a_exit_bound: assert property (p_exit_bound)
    else $error("exit time exceeded");

  property p_pause_cs;
    @(posedge clk) disable iff (!rst_n)
    !sel |=> !paused_r;
  endproperty
  a_pause_cs: assert property (p_pause_cs)
    else $error("paused without chip select");

  property p_pause_float;
    @(posedge clk) disable iff (!rst_n)
    paused_r |=> !so_oe_r;
  endproperty
  a_pause_float: assert property (p_pause_float)
    else $error("output driven while paused");

  property p_hold_wel;
    @(posedge clk) disable iff (!rst_n)
    (hold_abort && !wel_set) |=> !write_latch_flag_r ##0 abort_r;
  endproperty
  a_hold_wel: assert property (p_hold_wel)
    else $error("pause abort kept write latch");

  property p_guard;
    @(posedge clk) disable iff (!rst_n)
    paused_r ##0 $changed(pin_r.guard_n) |=> write_guard_r == !$past(pin_r.guard_n);
  endproperty
  a_guard: assert property (p_guard)
    else $error("guard frozen by pause");

endmodule : ssp_ctrl

// ---- bench/ssp_host.sv ----
// spi host model that drives the flash control pins
`timescale 1ns/100ps
module ssp_host
  import ssp_pkg::*;
(
  // clock
  input  wire logic clk,
  // pins toward the flash
  output ssp_pins_t pins
);
  // ==========================================================================
  // pin drivers, all changes at the falling clock edge
  initial pins = SSP_PINS_IDLE;

  task automatic half();
    repeat (8) @(negedge clk);
  endtask : half

  // a released data line must not keep showing its last bit
  task automatic set_cs(input logic v);
    @(negedge clk);
    pins.cs_n = v;
    if (v)
      pins.si = ~pins.si;
    half();
  endtask : set_cs

  // msb first, sampled by the flash on the rising clock edge
  task automatic put_bits(input logic [15:0] d, input int n);
    for (int i = 15; i > 15 - n; i--)
    begin
      pins.sck = 1'b0;
      pins.si  = d[i];
      half();
      pins.sck = 1'b1;
      half();
    end
  endtask : put_bits

  task automatic frame(input logic [15:0] d, input int n);
    set_cs(1'b0);
    put_bits(d, n);
    set_cs(1'b1);
  endtask : frame

  task automatic set_sck(input logic v);
    @(negedge clk);
    pins.sck = v;
  endtask : set_sck

  task automatic set_pause(input logic v);
    @(negedge clk);
    pins.pause_n = v;
  endtask : set_pause

  task automatic set_guard(input logic v);
    @(negedge clk);
    pins.guard_n = v;
  endtask : set_guard
endmodule : ssp_host

// ---- bench/test_serial_flash_sleep_and_pause_control.sv ----
// self-checking bench for the sleep, wake and pause front end
`timescale 1ns/100ps
module test_serial_flash_sleep_and_pause_control
  import ssp_pkg::*;
;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  ssp_pins_t pins;
  logic      busy = 1'b0;
  logic      wel_set = 1'b0;
  logic      wel_clr = 1'b0;
  logic      core_so = 1'b1;
  logic      core_so_en = 1'b1;
  logic      so_r, so_oe_r, standby_r, deep_sleep_r, paused_r;
  logic      write_latch_flag_r, write_guard_r, abort_r;
  ssp_cmd_t  cmd_r;
  int        num_errors = 0;
  int        n_tests = 0;
  int        n_cmd = 0;
  int        n_abort = 0;
  logic [7:0] last_op = 8'h00;

  always #2 clk = ~clk;

  ssp_host host (.clk(clk), .pins(pins));

  ssp_ctrl #(.ENTRY_CYC(4), .EXIT_CYC(4)) DUT (
    .clk(clk), .rst_n(rst_n), .pins(pins), .so_r(so_r), .so_oe_r(so_oe_r),
    .busy(busy), .core_so(core_so), .core_so_en(core_so_en), .wel_set(wel_set),
    .wel_clr(wel_clr), .cmd_r(cmd_r), .standby_r(standby_r),
    .deep_sleep_r(deep_sleep_r), .paused_r(paused_r),
    .write_latch_flag_r(write_latch_flag_r), .write_guard_r(write_guard_r),
    .abort_r(abort_r));

  // ==========================================================================
  // one-cycle pulses are counted as they occur
  always @(posedge clk)
  begin
    if (cmd_r.valid === 1'b1)
    begin
      n_cmd++;
      last_op = cmd_r.opcode;
    end
    if (abort_r === 1'b1)
      n_abort++;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    idle(4);
    chk(standby_r, 1'b1, "standby after reset");
    chk(deep_sleep_r, 1'b0, "sleep after reset");
  endtask : t_reset

  task automatic t_short_sleep();
    int a = n_abort;
    host.frame(16'hb900, 5);
    idle(8);
    chk(n_abort == a + 1, 1'b1, "short sleep abort");
    chk(standby_r, 1'b1, "short sleep standby");
  endtask : t_short_sleep

  task automatic t_busy_sleep();
    busy = 1'b1;
    idle(6);
    chk(standby_r, 1'b0, "busy standby");
    host.frame(16'hb900, 8);
    idle(16);
    chk(deep_sleep_r, 1'b0, "sleep while busy");
    busy = 1'b0;
    idle(6);
    chk(standby_r, 1'b1, "standby after busy");
  endtask : t_busy_sleep

  task automatic t_sleep();
    int c = n_cmd;
    host.frame(16'hb9a5, 16);
    for (int i = 0; i < 16 && deep_sleep_r !== 1'b1; i++)
      idle(1);
    chk(deep_sleep_r, 1'b1, "sleep entered");
    chk(n_cmd == c + 1, 1'b1, "one opcode");
    chk(last_op, 8'hb9, "sleep opcode");
  endtask : t_sleep

  task automatic t_sleep_ignore();
    int c = n_cmd;
    int a = n_abort;
    host.frame(16'h0500, 8);
    idle(8);
    chk(n_cmd == c, 1'b1, "cmd in sleep");
    host.frame(16'hab00, 4);
    idle(8);
    chk(n_abort == a + 1, 1'b1, "short wake abort");
    chk(deep_sleep_r, 1'b1, "still asleep");
  endtask : t_sleep_ignore

  task automatic t_wake();
    host.frame(16'habff, 16);
    for (int i = 0; i < 16 && deep_sleep_r !== 1'b0; i++)
      idle(1);
    chk(deep_sleep_r, 1'b0, "woken");
    idle(2);
    chk(standby_r, 1'b1, "standby after wake");
  endtask : t_wake

  task automatic t_pause();
    int c = n_cmd;
    int a = n_abort;
    wel_set = 1'b1;
    idle(1);
    wel_set = 1'b0;
    idle(2);
    chk(write_latch_flag_r, 1'b1, "latch set");
    host.set_cs(1'b0);
    host.put_bits(16'h9000, 4);
    chk(so_oe_r, 1'b1, "drive before pause");
    core_so = 1'b0;
    core_so_en = 1'b0;
    idle(3);
    chk(so_r, 1'b0, "data out follows core");
    chk(so_oe_r, 1'b0, "no drive without enable");
    core_so_en = 1'b1;
    idle(3);
    host.set_pause(1'b0);
    idle(8);
    chk(paused_r, 1'b0, "pause with clock high");
    host.set_sck(1'b0);
    idle(8);
    chk(paused_r, 1'b1, "pause at clock low");
    chk(so_oe_r, 1'b0, "float when paused");
    host.set_guard(1'b0);
    idle(6);
    chk(write_guard_r, 1'b1, "guard while paused");
    host.put_bits(16'hffff, 3);
    host.set_pause(1'b1);
    idle(8);
    chk(paused_r, 1'b1, "held with clock high");
    host.set_sck(1'b0);
    idle(8);
    chk(paused_r, 1'b0, "resume at clock low");
    host.set_guard(1'b1);
    host.put_bits(16'h6000, 4);
    idle(8);
    chk(write_guard_r, 1'b0, "guard released");
    chk(n_cmd == c + 1, 1'b1, "one opcode");
    chk(last_op, 8'h96, "clocks ignored");
    host.set_sck(1'b0);
    host.set_pause(1'b0);
    idle(8);
    host.set_cs(1'b1);
    chk(n_abort == a + 1, 1'b1, "pause abort");
    chk(write_latch_flag_r, 1'b0, "latch cleared");
    host.set_sck(1'b1);
    idle(6);
    chk(paused_r, 1'b0, "no pause, cs high");
    host.set_pause(1'b1);
    idle(6);
  endtask : t_pause

  // set and clear in one cycle: set wins
  task automatic t_latch();
    wel_set = 1'b1;
    wel_clr = 1'b1;
    idle(1);
    wel_set = 1'b0;
    wel_clr = 1'b0;
    idle(2);
    chk(write_latch_flag_r, 1'b1, "set wins");
    wel_clr = 1'b1;
    idle(1);
    wel_clr = 1'b0;
    idle(2);
    chk(write_latch_flag_r, 1'b0, "latch clear");
  endtask : t_latch

  // reset taken while asleep must come back in standby
  task automatic t_mid_reset();
    host.frame(16'hb900, 8);
    for (int i = 0; i < 16 && deep_sleep_r !== 1'b1; i++)
      idle(1);
    chk(deep_sleep_r, 1'b1, "asleep before reset");
    wel_set = 1'b1;
    idle(1);
    wel_set = 1'b0;
    idle(2);
    chk(write_latch_flag_r, 1'b0, "latch set in sleep");
    rst_n = 1'b0;
    idle(2);
    chk(deep_sleep_r, 1'b0, "sleep held in reset");
    rst_n = 1'b1;
    idle(4);
    chk(standby_r, 1'b1, "standby after mid reset");
    chk(deep_sleep_r, 1'b0, "awake after mid reset");
  endtask : t_mid_reset

  // ==========================================================================
  // verdict and run control
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    #100000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_latch();
    t_short_sleep();
    t_busy_sleep();
    t_sleep();
    t_sleep_ignore();
    t_wake();
    t_pause();
    t_mid_reset();
    final_report();
  end
endmodule : test_serial_flash_sleep_and_pause_control
